// [src/access_list_pkg.sv]
// Constants shared by the access list classifier and its per-entry matcher.
// Assumes one clock domain and a word-indexed register port on the host side.

package access_list_pkg;

  // ---------------------------------------------------------------------
  // Sizes and register map (word indices)
  // ---------------------------------------------------------------------
  localparam int          NUM_ENTRIES = 128;
  localparam int          IDX_W       = 7;
  localparam int          ADDR_W      = 9;
  localparam int          DATA_W      = 32;
  localparam int          PORT_W      = 5;
  localparam logic [1:0]  REGION_CFG  = 2'h0;
  localparam logic [1:0]  REGION_CNT  = 2'h1;
  localparam logic [1:0]  REGION_CTL  = 2'h2;
  localparam logic [8:0]  STAT_ADDR   = 9'h100;
  localparam logic [8:0]  MASK_ADDR   = 9'h101;
  localparam logic [8:0]  CTRL_ADDR   = 9'h102;
  localparam logic [8:0]  USER_ADDR   = 9'h103;
  localparam logic [8:0]  APPL_ADDR   = 9'h104;

  // ---------------------------------------------------------------------
  // Entry configuration word layout
  // ---------------------------------------------------------------------
  localparam int F_VALID    = 0;
  localparam int F_PSEL     = 1;
  localparam int F_PORT     = 3;
  localparam int F_POLICY   = 8;
  localparam int F_TYPE     = 11;
  localparam int F_DENY     = 14;
  localparam int F_LIM      = 15;
  localparam int F_COPY_EN  = 19;
  localparam int F_COPY     = 20;
  localparam int F_CPU      = 25;
  localparam int F_ONCE     = 26;
  localparam int F_USER     = 27;
  localparam int F_CONFLICT = 30;
  localparam int CFG_W      = 30;
  localparam int NUM_USERS  = 8;
  localparam logic [CFG_W-1:0] CFG_RESET = 30'h0000_0000;

  typedef enum logic [1:0] {
    PSEL_ANY    = 2'h0,
    PSEL_POLICY = 2'h1,
    PSEL_PORT   = 2'h2
  } port_sel_t;

  typedef enum logic [2:0] {
    FT_ANY   = 3'h0,
    FT_ETHERNET_TYPE_SELECTOR = 3'h1,
    FT_ARP   = 3'h2,
    FT_IPV4  = 3'h3,
    FT_ICMP  = 3'h4,
    FT_UDP   = 3'h5,
    FT_TCP   = 3'h6,
    FT_OTHER = 3'h7
  } frame_sel_t;

  // ---------------------------------------------------------------------
  // Frame codes, limiter, interrupt and control bits
  // ---------------------------------------------------------------------
  localparam logic [15:0] ETH_IPV4  = 16'h0800;
  localparam logic [15:0] ETH_ARP   = 16'h0806;
  localparam logic [15:0] ETH_RARP  = 16'h8035;
  localparam logic [15:0] ETH_IPV6  = 16'h86DD;
  localparam logic [7:0]  PROTO_ICMP = 8'h01;
  localparam logic [7:0]  PROTO_TCP  = 8'h06;
  localparam logic [7:0]  PROTO_UDP  = 8'h11;
  localparam logic [3:0]  LIM_OFF    = 4'h0;
  localparam int          IRQ_DENY     = 0;
  localparam int          IRQ_CPU      = 1;
  localparam int          IRQ_CONFLICT = 2;
  localparam int          IRQ_W        = 3;
  localparam logic [IRQ_W-1:0] MASK_RESET = 3'h0;
  localparam int          CTRL_CLR_CNT  = 0;
  localparam int          CTRL_CLR_ONCE = 1;

endpackage

// [src/access_entry_match.sv]
// Combinational match of one access entry against the current frame.
// Assumes the frame attributes are already decoded by the caller.
`timescale 1ns/1ps

module access_entry_match (
  // Entry configuration
  input  wire logic                             applied,
  input  wire logic [1:0]                       port_sel,
  input  wire logic [access_list_pkg::PORT_W-1:0] port_num,
  input  wire logic [2:0]                       policy,
  input  wire logic [2:0]                       frame_sel,
  // Decoded frame attributes
  input  wire logic [access_list_pkg::PORT_W-1:0] frm_port,
  input  wire logic [2:0]                       frm_policy,
  input  wire logic                             is_ipv4,
  input  wire logic                             is_ip,
  input  wire logic                             is_arp,
  input  wire logic [7:0]                       ip_proto,
  // Result
  output logic                                  hit
);

  logic port_ok;
  logic type_ok;
  logic known_proto;

  // --------------------------------------------------------------------
  // Ingress selector; policy codes 0..7 stand for groups 1..8.
  // --------------------------------------------------------------------
  always_comb begin
    unique case (port_sel)
      access_list_pkg::PSEL_ANY:    port_ok = 1'b1;
      access_list_pkg::PSEL_POLICY: port_ok = (frm_policy == policy);
      access_list_pkg::PSEL_PORT:   port_ok = (frm_port == port_num);
      default:                      port_ok = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------
  // Frame-type selector.
  // --------------------------------------------------------------------
  assign known_proto = (ip_proto == access_list_pkg::PROTO_ICMP) ||
                       (ip_proto == access_list_pkg::PROTO_UDP) ||
                       (ip_proto == access_list_pkg::PROTO_TCP);

  always_comb begin
    unique case (frame_sel)
      access_list_pkg::FT_ANY:   type_ok = 1'b1;
      access_list_pkg::FT_ETHERNET_TYPE_SELECTOR: type_ok = !is_ip && !is_arp;
      access_list_pkg::FT_ARP:   type_ok = is_arp;
      access_list_pkg::FT_IPV4:  type_ok = is_ipv4;
      access_list_pkg::FT_ICMP:
        type_ok = is_ipv4 && (ip_proto == access_list_pkg::PROTO_ICMP);
      access_list_pkg::FT_UDP:
        type_ok = is_ipv4 && (ip_proto == access_list_pkg::PROTO_UDP);
      access_list_pkg::FT_TCP:
        type_ok = is_ipv4 && (ip_proto == access_list_pkg::PROTO_TCP);
      default:                   type_ok = is_ipv4 && !known_proto;
    endcase
  end

  // Only installed, non-conflicting entries take part.
  assign hit = applied && port_ok && type_ok;

endmodule

// [src/access_list_frame_classifier.sv]
// Ingress access list classifier: per-frame lookup, actions, counters, status.
// Assumes frame attributes arrive from same-clock logic as a one-cycle strobe
// and that the host uses the word-indexed register port described below.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps

module access_list_frame_classifier #(
  parameter int HW_SLOTS = access_list_pkg::NUM_ENTRIES,
  parameter int CNT_W    = 32
) (
  // Clock and reset
  input  wire logic                                core_clk,
  input  wire logic                                resetn,
  // Register port
  input  wire logic [access_list_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [access_list_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic      [access_list_pkg::DATA_W-1:0]  reg_rdata,
  // Frame attributes from the ingress path
  input  wire logic                                frm_valid,
  input  wire logic [access_list_pkg::PORT_W-1:0]  frm_port,
  input  wire logic [2:0]                          frm_policy,
  input  wire logic [15:0]                         frm_ethertype,
  input  wire logic [7:0]                          frm_ip_proto,
  // Classification result to forwarding logic
  output logic                                     res_valid,
  output logic                                     res_hit,
  output logic      [access_list_pkg::IDX_W-1:0]   res_index,
  output logic                                     res_drop,
  output logic                                     res_learn,
  output logic      [3:0]                          res_limiter,
  output logic                                     res_copy_en,
  output logic      [access_list_pkg::PORT_W-1:0]  res_copy_port,
  output logic                                     res_to_cpu,
  // Interrupt
  output logic                                     irq
);

  localparam int N  = access_list_pkg::NUM_ENTRIES;
  localparam int AW = access_list_pkg::IDX_W + 1;

  logic [access_list_pkg::CFG_W-1:0]  cfg [N];
  logic [CNT_W-1:0]                   cnt [N];
  logic [N-1:0]                       conflict;
  logic [N-1:0]                       once_done;
  logic [N-1:0]                       hit_vec;
  logic [N-1:0]                       ethernet_type_selector_vec;
  logic [AW-1:0]                      applied_cnt;
  logic [access_list_pkg::IDX_W-1:0]  first_idx;
  logic                               any_hit;
  logic                               is_ipv4;
  logic                               is_ip;
  logic                               is_arp;
  logic [access_list_pkg::IDX_W-1:0]  widx;
  logic                               cfg_wr;
  logic                               cnt_wr;
  logic                               ctrl_wr;
  logic                               was_app;
  logic                               slot_free;
  logic [AW-1:0]                      next_applied;
  logic [access_list_pkg::IRQ_W-1:0]  irq_stat;
  logic [access_list_pkg::IRQ_W-1:0]  irq_mask;
  logic [access_list_pkg::IRQ_W-1:0]  irq_evt;
  logic [access_list_pkg::NUM_USERS-1:0] user_conf;
  logic [access_list_pkg::CFG_W-1:0]  fcfg;
  logic                               fire_cpu;

  // --------------------------------------------------------------------
  // Frame decode and write decode
  // --------------------------------------------------------------------
  // IPv6 counts as IP so Ethernet-type entries never see it either.
  assign is_ipv4 = (frm_ethertype == access_list_pkg::ETH_IPV4);
  assign is_ip   = is_ipv4 || (frm_ethertype == access_list_pkg::ETH_IPV6);
  assign is_arp  = (frm_ethertype == access_list_pkg::ETH_ARP) ||
                   (frm_ethertype == access_list_pkg::ETH_RARP);
  assign widx    = reg_addr[access_list_pkg::IDX_W-1:0];
  assign cfg_wr  = reg_wr && (reg_addr[8:7] == access_list_pkg::REGION_CFG);
  assign cnt_wr  = reg_wr && (reg_addr[8:7] == access_list_pkg::REGION_CNT);
  assign ctrl_wr = reg_wr && (reg_addr == access_list_pkg::CTRL_ADDR);

  // --------------------------------------------------------------------
  // Per-entry matchers, counters and first-hit flags
  // --------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_ent
      logic hit_here;

      access_entry_match u_match (
        .applied    (cfg[gi][access_list_pkg::F_VALID] && !conflict[gi]),
        .port_sel   (cfg[gi][access_list_pkg::F_PSEL +: 2]),
        .port_num   (cfg[gi][access_list_pkg::F_PORT +: access_list_pkg::PORT_W]),
        .policy     (cfg[gi][access_list_pkg::F_POLICY +: 3]),
        .frame_sel  (cfg[gi][access_list_pkg::F_TYPE +: 3]),
        .frm_port   (frm_port),
        .frm_policy (frm_policy),
        .is_ipv4    (is_ipv4),
        .is_ip      (is_ip),
        .is_arp     (is_arp),
        .ip_proto   (frm_ip_proto),
        .hit        (hit_vec[gi])
      );

      assign ethernet_type_selector_vec[gi] = (cfg[gi][access_list_pkg::F_TYPE +: 3] ==
                              access_list_pkg::FT_ETHERNET_TYPE_SELECTOR);
      assign hit_here = frm_valid && any_hit && (int'(first_idx) == gi);

      // A hit in the same cycle as a clear still counts: the count restarts at one.
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          cnt[gi] <= '0;
        end else begin
          cnt[gi] <= (((cnt_wr && int'(widx) == gi) ||
                       (ctrl_wr && reg_wdata[access_list_pkg::CTRL_CLR_CNT])) ?
                      '0 : cnt[gi]) + CNT_W'(hit_here);
        end
      end

      // Rewriting the entry re-arms its first-hit delivery; a hit wins over a clear.
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          once_done[gi] <= 1'b0;
        end else if (hit_here && cfg[gi][access_list_pkg::F_ONCE]) begin
          once_done[gi] <= 1'b1;
        end else if ((cfg_wr && int'(widx) == gi) ||
                     (ctrl_wr && reg_wdata[access_list_pkg::CTRL_CLR_ONCE])) begin
          once_done[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // List-order priority: the lowest matching index wins.
  // --------------------------------------------------------------------
  always_comb begin
    first_idx = '0;
    any_hit   = 1'b0;
    for (int k = N - 1; k >= 0; k--) begin
      if (hit_vec[k]) begin
        first_idx = k[access_list_pkg::IDX_W-1:0];
        any_hit   = 1'b1;
      end
    end
  end

  assign fcfg     = cfg[first_idx];
  assign fire_cpu = fcfg[access_list_pkg::F_CPU] ||
                    (fcfg[access_list_pkg::F_ONCE] && !once_done[first_idx]);

  // --------------------------------------------------------------------
  // Classification result, one cycle after the frame strobe
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      res_valid     <= 1'b0;
      res_hit       <= 1'b0;
      res_index     <= '0;
      res_drop      <= 1'b0;
      res_learn     <= 1'b0;
      res_limiter   <= access_list_pkg::LIM_OFF;
      res_copy_en   <= 1'b0;
      res_copy_port <= '0;
      res_to_cpu    <= 1'b0;
    end else begin
      res_valid     <= frm_valid;
      res_hit       <= frm_valid && any_hit;
      res_index     <= any_hit ? first_idx : '0;
      res_drop      <= frm_valid && any_hit && fcfg[access_list_pkg::F_DENY];
      res_learn     <= frm_valid && !(any_hit && fcfg[access_list_pkg::F_DENY]);
      res_limiter   <= any_hit ? fcfg[access_list_pkg::F_LIM +: 4] : access_list_pkg::LIM_OFF;
      res_copy_en   <= frm_valid && any_hit && fcfg[access_list_pkg::F_COPY_EN];
      res_copy_port <= any_hit ? fcfg[access_list_pkg::F_COPY +: access_list_pkg::PORT_W] : '0;
      res_to_cpu    <= frm_valid && any_hit && fire_cpu;
    end
  end

  // --------------------------------------------------------------------
  // Entry installation; entries beyond the hardware slots become conflicts.
  // --------------------------------------------------------------------
  assign was_app      = cfg[widx][access_list_pkg::F_VALID] && !conflict[widx];
  assign slot_free    = (applied_cnt - AW'(was_app)) < AW'(HW_SLOTS);
  assign next_applied = applied_cnt - AW'(was_app) +
                        AW'(reg_wdata[access_list_pkg::F_VALID] && slot_free);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int k = 0; k < N; k++) begin
        cfg[k] <= access_list_pkg::CFG_RESET;
      end
      conflict    <= '0;
      applied_cnt <= '0;
    end else if (cfg_wr) begin
      cfg[widx]      <= reg_wdata[access_list_pkg::CFG_W-1:0];
      conflict[widx] <= reg_wdata[access_list_pkg::F_VALID] && !slot_free;
      applied_cnt    <= next_applied;
    end
  end

  // Conflicts gathered per installing user; bit 8 of the read is the union.
  always_comb begin
    user_conf = '0;
    for (int k = 0; k < N; k++) begin
      if (conflict[k]) begin
        user_conf[cfg[k][access_list_pkg::F_USER +: 3]] = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Interrupt status (cleared by read, set wins) and mask
  // --------------------------------------------------------------------
  assign irq_evt[access_list_pkg::IRQ_DENY]     = frm_valid && any_hit &&
                                                  fcfg[access_list_pkg::F_DENY];
  assign irq_evt[access_list_pkg::IRQ_CPU]      = frm_valid && any_hit && fire_cpu;
  assign irq_evt[access_list_pkg::IRQ_CONFLICT] = cfg_wr &&
                                                  reg_wdata[access_list_pkg::F_VALID] && !slot_free;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat <= '0;
      irq_mask <= access_list_pkg::MASK_RESET;
      irq      <= 1'b0;
    end else begin
      irq_stat <= ((reg_rd && reg_addr == access_list_pkg::STAT_ADDR) ? '0 : irq_stat) | irq_evt;
      if (reg_wr && reg_addr == access_list_pkg::MASK_ADDR) begin
        irq_mask <= reg_wdata[access_list_pkg::IRQ_W-1:0];
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  // --------------------------------------------------------------------
  // Read port: data stands one cycle after the strobe, zero otherwise.
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr[8:7] == access_list_pkg::REGION_CFG) begin
      reg_rdata <= {1'b0, conflict[widx], 30'(cfg[widx])};
    end else if (reg_addr[8:7] == access_list_pkg::REGION_CNT) begin
      reg_rdata <= 32'(cnt[widx]);
    end else begin
      unique case (reg_addr)
        access_list_pkg::STAT_ADDR: reg_rdata <= 32'(irq_stat);
        access_list_pkg::MASK_ADDR: reg_rdata <= 32'(irq_mask);
        access_list_pkg::USER_ADDR: reg_rdata <= {23'h000000, |user_conf, user_conf};
        access_list_pkg::APPL_ADDR: reg_rdata <= 32'(applied_cnt);
        default:                    reg_rdata <= '0;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_deny_drops:   assert property (frm_valid && any_hit && fcfg[access_list_pkg::F_DENY]
                                   |=> res_drop && !res_learn)
    else $error("deny hit did not drop the frame");
  a_miss_passes:  assert property (frm_valid && !any_hit |=> res_valid && !res_hit
                                   && !res_drop && !res_to_cpu && !res_copy_en)
    else $error("missed frame took an entry action");
  // The reported index must have matched, and no lower index may have matched.
  a_first_wins:   assert property (res_hit |->
                    ((($past(hit_vec) >> res_index) & N'(1)) == N'(1)) &&
                    (($past(hit_vec) & ((N'(1) << res_index) - N'(1))) == '0))
    else $error("result index is not the first matching entry");
  a_ethernet_type_selector_excl:   assert property (frm_valid && (is_ip || is_arp) |->
                                   (hit_vec & ethernet_type_selector_vec) == '0)
    else $error("ethernet type entry hit by an IP or ARP frame");
  a_conflict_off: assert property ((hit_vec & conflict) == '0)
    else $error("conflicting entry took part in matching");
  a_limiter_sel:  assert property (frm_valid && any_hit |=>
                                   res_limiter == $past(fcfg[access_list_pkg::F_LIM +: 4]))
    else $error("limiter not taken from the hitting entry");
  a_once_quiet:   assert property (frm_valid && any_hit && !fcfg[access_list_pkg::F_CPU]
                                   && once_done[first_idx] |=> !res_to_cpu)
    else $error("first-hit entry sent a later frame to the processor");
  a_count_step:   assert property (frm_valid && any_hit && !reg_wr |=>
                    cnt[$past(first_idx)] == $past(cnt[first_idx]) + CNT_W'(1))
    else $error("hit counter did not advance by one");

  // Action outputs are checked against the entry that decided the frame.
  a_cpu_every:    assert property (frm_valid && any_hit && fcfg[access_list_pkg::F_CPU]
                                   |=> res_to_cpu)
    else $error("every-hit entry did not reach the processor");
  a_once_first:   assert property (frm_valid && any_hit && fcfg[access_list_pkg::F_ONCE]
                                   && !once_done[first_idx] |=> res_to_cpu)
    else $error("first hit of a first-hit entry did not reach the processor");
  a_copy_follows: assert property (frm_valid && any_hit && fcfg[access_list_pkg::F_COPY_EN]
                                   |=> res_copy_en && res_copy_port ==
                    $past(fcfg[access_list_pkg::F_COPY +: access_list_pkg::PORT_W]))
    else $error("copy port not taken from the hitting entry");
  a_learn_permit: assert property (frm_valid && !(any_hit && fcfg[access_list_pkg::F_DENY])
                                   |=> res_learn && !res_drop)
    else $error("permitted frame was not offered for learning");

  c_deny_hit:  cover property (frm_valid && any_hit && fcfg[access_list_pkg::F_DENY]);
  c_once_hit:  cover property (frm_valid && any_hit && fcfg[access_list_pkg::F_ONCE]
                               ##1 frm_valid && any_hit && once_done[first_idx]);
  c_miss:      cover property (frm_valid && !any_hit);
  c_conflict:  cover property (irq_evt[access_list_pkg::IRQ_CONFLICT]);

endmodule

// [test/frame_source.sv]
// Model of the ingress path that hands frame attributes to the classifier.
// Assumes one caller at a time and the classifier clock as its only timing.
`timescale 1ns/1ps

module frame_source (
  // Clock
  input  wire logic                               core_clk,
  // Frame attributes
  output logic                                    frm_valid,
  output logic [access_list_pkg::PORT_W-1:0]      frm_port,
  output logic [2:0]                              frm_policy,
  output logic [15:0]                             frm_ethertype,
  output logic [7:0]                              frm_ip_proto
);
  initial {frm_valid, frm_port, frm_policy, frm_ethertype, frm_ip_proto} = '0;

  // One strobe per frame; idle attributes are inverted so stale values never look valid.
  task automatic send(input logic [4:0] p, input logic [2:0] g, input logic [15:0] et,
                      input logic [7:0] pr);
    @(posedge core_clk);
    {frm_valid, frm_port, frm_policy, frm_ethertype, frm_ip_proto} <= {1'b1, p, g, et, pr};
    @(posedge core_clk);
    {frm_valid, frm_port, frm_policy, frm_ethertype, frm_ip_proto} <= {1'b0, ~p, ~g, ~et, ~pr};
  endtask
endmodule

// [test/tb_access_list_frame_classifier.sv]
// Self-checking bench for the access list classifier.
// Assumes the classifier is built with three hardware slots.
`timescale 1ns/1ps

module tb_access_list_frame_classifier;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [8:0]  reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        frm_valid, res_valid, res_hit, res_drop, res_learn, res_copy_en, res_to_cpu, irq;
  logic [4:0]  frm_port, res_copy_port;
  logic [2:0]  frm_policy;
  logic [15:0] frm_ethertype;
  logic [7:0]  frm_ip_proto;
  logic [6:0]  res_index;
  logic [3:0]  res_limiter;
  logic [7:0]  pr [4] = '{access_list_pkg::PROTO_ICMP, access_list_pkg::PROTO_UDP,
                          access_list_pkg::PROTO_TCP, 8'h02};
  int          err_total = 0;
  int          num_checks = 0;
  int          cyc = 0;
  // A miss: valid and learn only.
  localparam logic [31:0] MISS = 32'h0020_0800;

  access_list_frame_classifier #(.HW_SLOTS(3)) i_access_list_frame_classifier (.core_clk,
    .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .frm_valid, .frm_port,
    .frm_policy, .frm_ethertype, .frm_ip_proto, .res_valid, .res_hit, .res_index, .res_drop,
    .res_learn, .res_limiter, .res_copy_en, .res_copy_port, .res_to_cpu, .irq);
  frame_source i_frame_source (.core_clk, .frm_valid, .frm_port, .frm_policy, .frm_ethertype,
    .frm_ip_proto);

  always #12.5 core_clk = ~core_clk;

  // Cut a hang short; the whole run needs about 115 cycles.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge.
  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    @(posedge core_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  // Copy port is only meaningful while copy is enabled, so it is masked otherwise.
  task automatic fr(input logic [4:0] p, input logic [2:0] g, input logic [15:0] et,
                    input logic [7:0] q, input logic [31:0] e);
    i_frame_source.send(p, g, et, q);
    #1 chk(32'({res_valid, res_hit, res_index, res_drop, res_learn, res_limiter, res_copy_en,
                res_copy_port & {5{res_copy_en}}, res_to_cpu}), e);
  endtask

  function automatic logic [31:0] en(int ps, pt, pg, ty, dn, lm, ce, cp, cu, on);
    return 32'(1 + (ps << 1) + (pt << 3) + (pg << 8) + (ty << 11) + (dn << 14) + (lm << 15)
               + (ce << 19) + (cp << 20) + (cu << 25) + (on << 26));
  endfunction

  function automatic logic [31:0] x(int h, ix, dn, lm, ce, cp, cu);
    return 32'({1'b1, h[0], ix[6:0], dn[0], ~dn[0], lm[3:0], ce[0], cp[4:0], cu[0]});
  endfunction

  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    rd(9'h1FF, 32'h0);
    wr(9'h07F, 32'h0000_0FF8);
    rd(9'h07F, 32'h0000_0FF8);
    wr(9'h000, en(2, 3, 0, 2, 1, 15, 1, 7, 0, 0));
    wr(9'h001, en(1, 0, 1, 1, 0, 0, 0, 0, 0, 1));
    wr(9'h101, 32'h1);
    fr(3, 0, access_list_pkg::ETH_ARP, 0, x(1, 0, 1, 15, 1, 7, 0));
    fr(3, 0, access_list_pkg::ETH_RARP, 0, x(1, 0, 1, 15, 1, 7, 0));
    fr(4, 0, access_list_pkg::ETH_ARP, 0, MISS);
    chk(32'(irq), 32'h1);
    rd(9'h100, 32'h1);
    repeat (2) @(posedge core_clk);
    #1 chk(32'(irq), 32'h0);
    $display("test port and action done");
    fr(5, 1, access_list_pkg::ETH_IPV4, access_list_pkg::PROTO_TCP, MISS);
    fr(5, 1, access_list_pkg::ETH_ARP, 0, MISS);
    fr(5, 1, 16'h1234, 0, x(1, 1, 0, 0, 0, 0, 1));
    fr(5, 1, 16'h1234, 0, x(1, 1, 0, 0, 0, 0, 0));
    fr(5, 2, 16'h1234, 0, MISS);
    rd(9'h080, 32'h2);
    rd(9'h081, 32'h2);
    wr(9'h081, 32'h0);
    rd(9'h081, 32'h0);
    $display("test type and counters done");
    for (int t = 3; t < 8; t++) begin
      wr(9'h002, en(0, 0, 0, t, 0, t, 0, 0, 0, 0));
      for (int j = 0; j < 4; j++) begin
        fr(9, 0, access_list_pkg::ETH_IPV4, pr[j],
           (t == 3 || t == j + 4) ? x(1, 2, 0, t, 0, 0, 0) : MISS);
      end
    end
    $display("test ipv4 subtypes done");
    wr(9'h002, en(0, 0, 0, 0, 0, 0, 0, 0, 1, 0));
    fr(5, 1, 16'h1234, 0, x(1, 1, 0, 0, 0, 0, 0));
    fr(5, 2, 16'h1234, 0, x(1, 2, 0, 0, 0, 0, 1));
    fr(5, 1, access_list_pkg::ETH_IPV6, 0, x(1, 2, 0, 0, 0, 0, 1));
    wr(9'h003, en(0, 0, 0, 0, 0, 0, 0, 0, 0, 0));
    rd(9'h003, en(0, 0, 0, 0, 0, 0, 0, 0, 0, 0) | 32'h4000_0000);
    rd(9'h104, 32'h3);
    rd(9'h103, 32'h101);
    wr(9'h102, 32'h3);
    rd(9'h080, 32'h0);
    fr(5, 1, 16'h1234, 0, x(1, 1, 0, 0, 0, 0, 1));
    $display("test order and conflict done");
    report_and_stop();
  end
endmodule
